// ==== hdl/driver_fault_protection.sv ====
// fault protection, standby and serial word handling of the driver
`timescale 1ns/100ps

// How it works
// - any warning comparator sets prewarning flag
// - flag clears when comparators release
// - chip select low shows prewarning on data out
// - early chip select high aborts, words unchanged
// - thermal shutdown disables switch, status low
// - thermal shutdown sets overload flag
// - re-enable needs cool switch and reset request
// - enabled overcurrent trips after counted delay
// - overcurrent trip sets overload, status low
// - disabled overcurrent shutdown never trips
// - reset request clears overload, re-enables switches
// - standby forces stages off, serial stays alive
// - standby bit one resumes stage control
// - control word layout, reset value E000
// - status prewarn bit 0, overload bit 13
// - status bits 1-6 report switch states
// - status bit 14 mirrors standby
module driver_fault_protection (
	input  wire logic                      clock,          // core clock
	input  wire logic                      reset,          // async, high
	input  wire logic                      serialClock,    // host clock
	input  wire logic                      chipSelectN,    // frame select
	input  wire logic                      serialDataIn,   // host data
	output logic                           serialDataOut,  // status data
	output logic                           serialDataOutEn,// data out drive
	input  wire fault_prot_pkg::switch_vec_t warnComparator, // prewarn
	input  wire fault_prot_pkg::switch_vec_t hotComparator,  // shutdown
	input  wire fault_prot_pkg::switch_vec_t overCurrentIn,  // current
	output fault_prot_pkg::switch_vec_t    stageEnable,    // stage drive
	output logic                           standbyActive,  // in standby
	output logic                           overloadActive, // overload set
	output logic                           prewarnActive   // prewarning
);
	typedef enum {FRAME_IDLE, FRAME_OPEN, FRAME_FULL} frame_t;

	// crossing carrier, declared first since the toggle sync reads it
	link_if lnk ();

	// ==========================================================
	// synchronisers
	logic                        csMeta_reg;
	logic                        csSync_reg;
	logic                        csPrev_reg;
	logic                        tglMeta_reg;
	logic                        tglSync_reg;
	logic                        tglPrev_reg;
	fault_prot_pkg::switch_vec_t warnMeta_reg;
	fault_prot_pkg::switch_vec_t warnSync_reg;
	fault_prot_pkg::switch_vec_t hotMeta_reg;
	fault_prot_pkg::switch_vec_t hotSync_reg;
	fault_prot_pkg::switch_vec_t ocMeta_reg;
	fault_prot_pkg::switch_vec_t ocSync_reg;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			csMeta_reg <= 1'b1;
			csSync_reg <= 1'b1;
			csPrev_reg <= 1'b1;
		end else begin
			csMeta_reg <= chipSelectN;
			csSync_reg <= csMeta_reg;
			csPrev_reg <= csSync_reg;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tglMeta_reg <= 1'b0;
			tglSync_reg <= 1'b0;
			tglPrev_reg <= 1'b0;
		end else begin
			tglMeta_reg <= lnk.doneTgl;
			tglSync_reg <= tglMeta_reg;
			tglPrev_reg <= tglSync_reg;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			warnMeta_reg <= '0;
			warnSync_reg <= '0;
			hotMeta_reg <= '0;
			hotSync_reg <= '0;
			ocMeta_reg <= '0;
			ocSync_reg <= '0;
		end else begin
			warnMeta_reg <= warnComparator;
			warnSync_reg <= warnMeta_reg;
			hotMeta_reg <= hotComparator;
			hotSync_reg <= hotMeta_reg;
			ocMeta_reg <= overCurrentIn;
			ocSync_reg <= ocMeta_reg;
		end
	end

	// ==========================================================
	// serial link
	serial_link linkSide (
		.serialClock (serialClock),
		.reset       (reset),
		.chipSelectN (chipSelectN),
		.dataIn      (serialDataIn),
		.dataOut     (serialDataOut),
		.dataOutEn   (serialDataOutEn),
		.lnk         (lnk)
	);

	// ==========================================================
	// frame tracking
	frame_t frame_reg;
	frame_t frame_next;

	wire csFall = csPrev_reg & ~csSync_reg;
	wire csRise = ~csPrev_reg & csSync_reg;
	wire wordArrived = tglSync_reg ^ tglPrev_reg;
	// a short frame never reaches a full word, so nothing is applied
	wire applyWord = csRise & ((frame_reg == FRAME_FULL) |
		((frame_reg == FRAME_OPEN) & wordArrived));

	always_comb begin
		frame_next = frame_reg;
		case (frame_reg)
			FRAME_IDLE: begin
				if (csFall) begin
					frame_next = FRAME_OPEN;
				end
			end
			FRAME_OPEN: begin
				if (csRise) begin
					frame_next = FRAME_IDLE;
				end else if (wordArrived) begin
					frame_next = FRAME_FULL;
				end
			end
			FRAME_FULL: begin
				if (csRise) begin
					frame_next = FRAME_IDLE;
				end
			end
			default: begin
				frame_next = FRAME_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			frame_reg <= FRAME_IDLE;
		end else begin
			frame_reg <= frame_next;
		end
	end

	// ==========================================================
	// control word
	fault_prot_pkg::word_t ctrl_reg;
	fault_prot_pkg::word_t ctrl_next;
	logic                  srrPulse_reg;

	// request bit is never stored, so it cannot hold a reset
	assign ctrl_next = applyWord ? {lnk.rxHold[15:1], 1'b0} : ctrl_reg;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_reg <= fault_prot_pkg::CTRL_RESET;
			srrPulse_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			srrPulse_reg <= applyWord &
				lnk.rxHold[fault_prot_pkg::CTRL_SRR_BIT];
		end
	end

	// standby bit low means standby
	wire standby = ~ctrl_reg[fault_prot_pkg::CTRL_STANDBY_BIT];
	wire currentTripEnable = ctrl_reg[fault_prot_pkg::CTRL_OCS_BIT];
	wire fault_prot_pkg::switch_vec_t switchReq =
		ctrl_reg[fault_prot_pkg::CTRL_SWITCH_LSB +: fault_prot_pkg::NUM_SWITCHES];

	// ==========================================================
	// per-switch protection
	fault_prot_pkg::switch_vec_t stageOnVec;
	fault_prot_pkg::switch_vec_t tripVec;

	genvar sw;
	generate
		for (sw = 0; sw < fault_prot_pkg::NUM_SWITCHES; sw++) begin : g_guard
			switch_guard guard (
				.clock             (clock),
				.reset             (reset),
				.stageRequest      (switchReq[sw] & ~standby),
				.hotShutdown       (hotSync_reg[sw]),
				.overCurrent       (ocSync_reg[sw]),
				.currentTripEnable (currentTripEnable),
				.statusResetPulse  (srrPulse_reg),
				.stageOn           (stageOnVec[sw]),
				.tripEvent         (tripVec[sw])
			);
		end
	endgenerate

	// ==========================================================
	// flags and outputs
	fault_prot_pkg::switch_vec_t stageEnable_reg;
	logic                        overload_reg;
	logic                        overload_next;
	logic                        prewarn_reg;
	logic                        standby_reg;
	fault_prot_pkg::word_t       snap_reg;
	fault_prot_pkg::word_t       statusWord;

	// a trip in the clearing cycle keeps the flag set
	assign overload_next = (|tripVec) | (overload_reg & ~srrPulse_reg);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stageEnable_reg <= '0;
			overload_reg <= 1'b0;
			prewarn_reg <= 1'b0;
			standby_reg <= 1'b0;
		end else begin
			stageEnable_reg <= stageOnVec;
			overload_reg <= overload_next;
			// comparators carry the hysteresis themselves
			prewarn_reg <= |warnSync_reg;
			standby_reg <= standby;
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[fault_prot_pkg::STAT_PREWARN_BIT] = prewarn_reg;
		statusWord[fault_prot_pkg::STAT_SWITCH_LSB +:
			fault_prot_pkg::NUM_SWITCHES] = stageEnable_reg;
		statusWord[fault_prot_pkg::STAT_OVERLOAD_BIT] = overload_reg;
		statusWord[fault_prot_pkg::STAT_STANDBY_BIT] = standby_reg;
		statusWord[fault_prot_pkg::STAT_SUPPLY_FAIL_BIT] = 1'b0;
	end

	// frozen at frame start so the link reads a steady word
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			snap_reg <= '0;
		end else if (csFall) begin
			snap_reg <= statusWord;
		end
	end

	assign lnk.statusSnap = snap_reg;
	assign lnk.prewarnNow = prewarn_reg;
	assign stageEnable = stageEnable_reg;
	assign standbyActive = standby_reg;
	assign overloadActive = overload_reg;
	assign prewarnActive = prewarn_reg;
endmodule // driver_fault_protection

// ==== hdl/fault_prot_pkg.sv ====
// constants and types shared by the driver fault-protection block
package fault_prot_pkg;

	// ==========================================================
	// word layout
	localparam int WORD_BITS = 16;
	localparam int NUM_SWITCHES = 6;
	typedef logic [WORD_BITS-1:0] word_t;
	typedef logic [NUM_SWITCHES-1:0] switch_vec_t;

	// ==========================================================
	// control word fields
	localparam int CTRL_STANDBY_BIT = 15;
	localparam int CTRL_OCS_BIT = 14;
	localparam int CTRL_OPEN_LOAD_BIT = 13;
	localparam int CTRL_SWITCH_LSB = 1;
	localparam int CTRL_SRR_BIT = 0;
	localparam word_t CTRL_RESET = 16'hE000;

	// ==========================================================
	// status word fields
	localparam int STAT_PREWARN_BIT = 0;
	localparam int STAT_SWITCH_LSB = 1;
	localparam int STAT_OVERLOAD_BIT = 13;
	localparam int STAT_STANDBY_BIT = 14;
	localparam int STAT_SUPPLY_FAIL_BIT = 15;

	// ==========================================================
	// serial frame counting
	localparam int BIT_COUNT_W = 5;
	localparam logic [BIT_COUNT_W-1:0] LAST_BIT_INDEX = 5'h0F;
	localparam logic [BIT_COUNT_W-1:0] FRAME_FULL_COUNT = 5'h10;
	localparam int SERIAL_CLOCK_MAX_KHZ = 2000;

	// ==========================================================
	// timing
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int SHUTDOWN_DELAY_NS = 10000;
	localparam int SHUTDOWN_DELAY_CYCLES =
		(SHUTDOWN_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int DELAY_W = $clog2(SHUTDOWN_DELAY_CYCLES + 1);
	localparam logic [DELAY_W-1:0] DELAY_LAST =
		DELAY_W'(SHUTDOWN_DELAY_CYCLES - 1);

endpackage

// ==== hdl/link_if.sv ====
// carrier between the core domain and the serial-clock domain
`timescale 1ns/100ps
interface link_if;
	fault_prot_pkg::word_t statusSnap;   // frozen status for the frame
	logic                  prewarnNow;   // live prewarning flag
	fault_prot_pkg::word_t rxHold;       // last complete received word
	logic                  doneTgl;      // flips per complete word

	modport core (
		output statusSnap,
		output prewarnNow,
		input  rxHold,
		input  doneTgl
	);
	modport link (
		input  statusSnap,
		input  prewarnNow,
		output rxHold,
		output doneTgl
	);
endinterface // link_if

// ==== hdl/serial_link.sv ====
// shift logic on the host's serial clock
`timescale 1ns/100ps
module serial_link (
	input  wire logic serialClock, // link clock from host
	input  wire logic reset,       // async, active high
	input  wire logic chipSelectN, // frame select, active low
	input  wire logic dataIn,      // serial data from host
	output logic      dataOut,     // serial data to host
	output logic      dataOutEn,   // high while driving data out
	link_if.link      lnk          // crossing to core domain
);
	logic [fault_prot_pkg::BIT_COUNT_W-1:0] bitCount_reg;
	fault_prot_pkg::word_t                  tx_reg;
	fault_prot_pkg::word_t                  rx_reg;
	fault_prot_pkg::word_t                  hold_reg;
	logic                                   toggle_reg;

	// chip select high ends the frame without a clock edge
	wire frameClear = reset | chipSelectN;
	wire firstBit = bitCount_reg == '0;
	wire lastBit = bitCount_reg == fault_prot_pkg::LAST_BIT_INDEX;
	wire frameFull = bitCount_reg == fault_prot_pkg::FRAME_FULL_COUNT;

	// prewarning shown before any serial clock edge
	assign dataOut = firstBit ? lnk.prewarnNow : tx_reg[0];
	assign dataOutEn = ~chipSelectN;
	assign lnk.rxHold = hold_reg;
	assign lnk.doneTgl = toggle_reg;

	always_ff @(posedge serialClock or posedge frameClear) begin
		if (frameClear) begin
			bitCount_reg <= '0;
			tx_reg <= '0;
			rx_reg <= '0;
		end else if (!frameFull) begin
			bitCount_reg <= bitCount_reg + 1'b1;
			rx_reg <= {dataIn, rx_reg[15:1]};
			tx_reg <= firstBit ? {1'b0, lnk.statusSnap[15:1]}
				: {1'b0, tx_reg[15:1]};
		end
	end

	// hold survives chip select so the core can read it later
	always_ff @(posedge serialClock or posedge reset) begin
		if (reset) begin
			hold_reg <= '0;
			toggle_reg <= 1'b0;
		end else if (lastBit && !chipSelectN) begin
			hold_reg <= {dataIn, rx_reg[15:1]};
			toggle_reg <= ~toggle_reg;
		end
	end
endmodule // serial_link

// ==== hdl/switch_guard.sv ====
// per-switch protection latch with overcurrent shutdown delay
`timescale 1ns/100ps
module switch_guard (
	input  wire logic clock,            // core clock
	input  wire logic reset,            // async, active high
	input  wire logic stageRequest,     // host wants stage on
	input  wire logic hotShutdown,      // synced thermal shutdown
	input  wire logic overCurrent,      // synced overcurrent detect
	input  wire logic currentTripEnable,// overcurrent shutdown enabled
	input  wire logic statusResetPulse, // one-cycle reset request
	output logic      stageOn,          // stage actually on
	output logic      tripEvent         // protection fired this cycle
);
	logic [fault_prot_pkg::DELAY_W-1:0] delay_reg;
	logic [fault_prot_pkg::DELAY_W-1:0] delay_next;
	logic                               disabled_reg;
	logic                               disabled_next;

	wire stageActive = stageRequest & ~disabled_reg;
	// counts only while the fault persists on a live stage
	wire counting = currentTripEnable & overCurrent & stageActive;
	wire delayDone = delay_reg == fault_prot_pkg::DELAY_LAST;
	wire currentTrip = counting & delayDone;
	// still hot blocks the release
	wire releaseOk = statusResetPulse & ~hotShutdown;

	assign tripEvent = hotShutdown | currentTrip;
	assign stageOn = stageActive;
	// a trip in the clearing cycle wins
	assign disabled_next = tripEvent | (disabled_reg & ~releaseOk);
	assign delay_next = !counting ? '0 :
		(delayDone ? delay_reg : delay_reg + 1'b1);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			delay_reg <= '0;
			disabled_reg <= 1'b0;
		end else begin
			delay_reg <= delay_next;
			disabled_reg <= disabled_next;
		end
	end
endmodule // switch_guard

// ==== test/driver_fault_protection_monitor.sv ====
// assertion checker on the top ports of the fault-protection block
`timescale 1ns/100ps
module driver_fault_protection_monitor (
	input wire logic                        clock,           // core clock
	input wire logic                        reset,           // async, high
	input wire logic                        serialClock,     // link clock
	input wire logic                        chipSelectN,     // frame select
	input wire logic                        serialDataIn,    // host data
	input wire logic                        serialDataOut,   // device data
	input wire logic                        serialDataOutEn, // drive enable
	input wire fault_prot_pkg::switch_vec_t warnComparator,  // prewarn in
	input wire fault_prot_pkg::switch_vec_t hotComparator,   // shutdown in
	input wire fault_prot_pkg::switch_vec_t overCurrentIn,   // current in
	input wire fault_prot_pkg::switch_vec_t stageEnable,     // stage drive
	input wire logic                        standbyActive,   // standby
	input wire logic                        overloadActive,  // overload
	input wire logic                        prewarnActive    // prewarning
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// ==========
	// cycles since a fault input was last seen, saturating
	logic [3:0] quietCount_reg;
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			quietCount_reg <= 4'hF;
		else if (hotComparator != '0 || overCurrentIn != '0)
			quietCount_reg <= 4'h0;
		else if (quietCount_reg != 4'hF)
			quietCount_reg <= quietCount_reg + 4'h1;
	end

	// ==========
	// sequences; lengths cover the two-flop input sync
	sequence warnHeld;
		(warnComparator != '0) [*5];
	endsequence
	sequence warnGone;
		(warnComparator == '0) [*5];
	endsequence
	sequence hotHeld;
		(hotComparator != '0 && $stable(hotComparator)) [*4];
	endsequence

	// ==========
	// properties
	prewarn_set_a: assert property (warnHeld |-> prewarnActive)
		else $error("prewarning flag missing while warning held");
	prewarn_clear_a: assert property (warnGone |-> !prewarnActive)
		else $error("prewarning flag stuck after release");
	dout_drive_a: assert property (serialDataOutEn == !chipSelectN)
		else $error("data out enable does not follow chip select");
	hot_off_a: assert property (
		hotHeld |-> (stageEnable & hotComparator) == '0)
		else $error("hot switch still enabled");
	hot_overload_a: assert property (hotHeld |-> overloadActive)
		else $error("overload flag missing on thermal shutdown");
	overload_cause_a: assert property (
		$rose(overloadActive) |-> quietCount_reg < 4'h8)
		else $error("overload flag rose without a fault input");
	overload_clear_a: assert property (
		$fell(overloadActive) |-> $past(chipSelectN, 2))
		else $error("overload flag cleared without a finished frame");
	standby_off_a: assert property (
		standbyActive [*2] |-> stageEnable == '0)
		else $error("stage enabled during standby");
endmodule // driver_fault_protection_monitor

// ==== test/driver_fault_protection_tb.sv ====
// self-checking bench for the driver fault-protection block
`timescale 1ns/100ps
module driver_fault_protection_tb;
	logic                        clock;
	logic                        reset;
	logic                        serialClock;
	logic                        chipSelectN;
	logic                        serialDataIn;
	logic                        serialDataOut;
	logic                        serialDataOutEn;
	fault_prot_pkg::switch_vec_t warnComparator;
	fault_prot_pkg::switch_vec_t hotComparator;
	fault_prot_pkg::switch_vec_t overCurrentIn;
	fault_prot_pkg::switch_vec_t stageEnable;
	logic                        standbyActive;
	logic                        overloadActive;
	logic                        prewarnActive;
	fault_prot_pkg::word_t       rx;
	int                          mismatches = 0;
	int                          comparisons = 0;
	int                          cycles = 0;

	driver_fault_protection i_driver_fault_protection (.clock, .reset,
		.serialClock, .chipSelectN, .serialDataIn, .serialDataOut,
		.serialDataOutEn, .warnComparator, .hotComparator, .overCurrentIn,
		.stageEnable, .standbyActive, .overloadActive, .prewarnActive);
	host_serial_model i_host_serial_model (.serialClock, .chipSelectN,
		.serialDataIn, .serialDataOut);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ==========
	// tasks
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input fault_prot_pkg::word_t seen,
		input fault_prot_pkg::word_t want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic access(input fault_prot_pkg::word_t tx, input int bits);
		i_host_serial_model.frame(tx, bits, rx);
		settle(6);
	endtask
	task automatic outs(input logic [5:0] st, input logic overload_flag,
		input logic sb, input logic pw);
		check({7'h00, prewarnActive, standbyActive, overloadActive,
			stageEnable}, {7'h00, pw, sb, overload_flag, st});
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ==========
	// main sequence
	initial begin
		reset = 1'b1;
		warnComparator = '0;
		hotComparator = '0;
		overCurrentIn = '0;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		settle(2);
		outs(6'h00, 1'b0, 1'b0, 1'b0);
		access(16'hE000, 16);
		check(rx, 16'h0000);
		access(16'hC07E, 16);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		access(16'hC07E, 16);
		check(rx, 16'h007E);
		@(posedge clock) warnComparator <= 6'h04;
		settle(8);
		outs(6'h3F, 1'b0, 1'b0, 1'b1);
		access(16'h0000, 0);
		check({15'h0000, rx[0]}, 16'h0001);
		access(16'h0000, 9);
		outs(6'h3F, 1'b0, 1'b0, 1'b1);
		access(16'hC07E, 16);
		check(rx, 16'h007F);
		@(posedge clock) warnComparator <= 6'h00;
		settle(8);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		@(posedge clock) hotComparator <= 6'h02;
		settle(8);
		outs(6'h3D, 1'b1, 1'b0, 1'b0);
		access(16'hC07F, 16);
		check(rx, 16'h207A);
		outs(6'h3D, 1'b1, 1'b0, 1'b0);
		@(posedge clock) hotComparator <= 6'h00;
		settle(8);
		outs(6'h3D, 1'b1, 1'b0, 1'b0);
		access(16'hC07F, 16);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		@(posedge clock) hotComparator <= 6'h01;
		settle(8);
		@(posedge clock) hotComparator <= 6'h00;
		settle(8);
		outs(6'h3E, 1'b1, 1'b0, 1'b0);
		access(16'hC07F, 16);
		// trip needs the full shutdown delay of held overcurrent
		@(posedge clock) overCurrentIn <= 6'h08;
		settle(900);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		settle(200);
		outs(6'h37, 1'b1, 1'b0, 1'b0);
		@(posedge clock) overCurrentIn <= 6'h00;
		access(16'hC07F, 16);
		check(rx, 16'h206E);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		access(16'h807E, 16);
		@(posedge clock) overCurrentIn <= 6'h10;
		settle(1200);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		@(posedge clock) overCurrentIn <= 6'h00;
		access(16'h007E, 16);
		outs(6'h00, 1'b0, 1'b1, 1'b0);
		access(16'h007E, 16);
		check(rx, 16'h4000);
		access(16'h807E, 16);
		outs(6'h3F, 1'b0, 1'b0, 1'b0);
		give_verdict();
	end
endmodule // driver_fault_protection_tb

bind driver_fault_protection driver_fault_protection_monitor
	i_driver_fault_protection_monitor (.clock, .reset, .serialClock,
	.chipSelectN, .serialDataIn, .serialDataOut, .serialDataOutEn,
	.warnComparator, .hotComparator, .overCurrentIn, .stageEnable,
	.standbyActive, .overloadActive, .prewarnActive);

// ==== test/host_serial_model.sv ====
// host side of the serial link: frames, quick reads and aborts
`timescale 1ns/100ps
module host_serial_model (
	output logic      serialClock,  // link clock, still outside frames
	output logic      chipSelectN,  // frame select, active low
	output logic      serialDataIn, // data to device
	input  wire logic serialDataOut // data from device
);
	initial begin
		serialClock = 1'b0;
		chipSelectN = 1'b1;
		serialDataIn = 1'b0;
	end

	// bits below 16 end the frame early, which the device must ignore
	task automatic frame(input fault_prot_pkg::word_t tx, input int bits,
		output fault_prot_pkg::word_t rx);
		rx = '0;
		#7 chipSelectN = 1'b0;
		#64;
		rx[0] = serialDataOut;
		for (int k = 0; k < bits; k++) begin
			rx[k] = serialDataOut;
			serialDataIn = tx[k];
			#32 serialClock = 1'b1;
			#32 serialClock = 1'b0;
		end
		// released line shows the inverse, not a stale bit
		serialDataIn = ~serialDataIn;
		#32 chipSelectN = 1'b1;
		#64;
	endtask
endmodule // host_serial_model
